// File: design/tlb_translation_control_regs.sv
// translation buffer, its management registers and system control registers
`timescale 1ns/1ps
module tlb_translation_control_regs #(
  parameter logic [7:0] PART_KIND = 8'h5A, // arbitrary value
  parameter logic [7:0] STEPPING  = 8'h10  // arbitrary value
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire tlb_ctrl_pkg::reg_wr_s     reg_wr_i,
  input  wire logic [4:0]                reg_rd_idx_i,
  output logic [31:0]                    reg_rd_data_o,
  input  wire tlb_ctrl_pkg::tlb_op_e     tlb_op_i,
  input  wire logic                      instr_step_i,
  input  wire tlb_ctrl_pkg::trans_req_s  trans_req_i,
  output tlb_ctrl_pkg::trans_resp_s      trans_resp_o,
  input  wire logic                      ll_valid_i,
  input  wire logic [31:0]               ll_paddr_i,
  input  wire logic                      tag_store_i,
  input  wire logic [2:0]                ratio_pin_i,
  output logic [3:0]                     writeback_pattern_o,
  output logic                           endian_select_o,
  output logic [2:0]                     kseg0_cache_mode_o
);
  import tlb_ctrl_pkg::*;

  typedef struct packed {
    tlb_entry_s [ENTRIES-1:0] tlb;
    logic                     probe_fail;
    logic [5:0]               index;
    logic [5:0]               random;
    logic [5:0]               locked;
    logic [25:0]              lo0;
    logic [25:0]              lo1;
    logic [11:0]              page_size;
    logic [1:0]               hi_region;
    logic [26:0]              hi_virtual_pair_number;
    logic [7:0]               hi_tag;
    logic [2:0]               ratio_s1;
    logic [2:0]               ratio_s2;
    logic [2:0]               ratio_s3;
    logic [2:0]               clock_ratio;
    logic [3:0]               writeback_pattern;
    logic                     endian_select;
    logic                     spare_sw_bits;
    logic [2:0]               kseg0_cache_mode;
    logic [31:0]              linked_load_phys;
    logic [31:0]              line_tag_low;
    logic [31:0]              rd_data;
    trans_resp_s              resp;
  } state_s;

  state_s st;
  state_s next_st;

  // pair number of an address, 32-bit form sign-extended
  function automatic logic [26:0] pair_of(input logic [63:0] va, input logic mode64);
    if (mode64) begin
      pair_of = va[39:13];
    end else begin
      pair_of = {{8{va[31]}}, va[31:13]};
    end
  endfunction

  // region bits of an address, 32-bit form sign-extended
  function automatic logic [1:0] region_of(input logic [63:0] va, input logic mode64);
    if (mode64) begin
      region_of = va[63:62];
    end else begin
      region_of = {2{va[31]}};
    end
  endfunction

  // lookup outcome: refill, invalid, modified
  function automatic logic [2:0] fault_of(input logic hit, input page_half_s h, input logic store);
    if (!hit) begin
      fault_of = 3'b100;
    end else if (!h.present) begin
      fault_of = 3'b010;
    end else if (store && !h.write_ok) begin
      fault_of = 3'b001;
    end else begin
      fault_of = 3'b000;
    end
  endfunction

  // pair number and tag compare of one entry
  function automatic logic entry_hit(input tlb_entry_s e, input logic [63:0] va,
                                     input logic mode64, input logic [7:0] tag);
    logic [26:0] care;
    logic [26:0] vpn;
    logic        hit;
    care = {15'h7FFF, ~e.mask};
    if (mode64) begin
      vpn = pair_of(va, 1'b1);
      hit = ((vpn & care) == (e.virtual_pair_number & care)) && (va[63:62] == e.region);
    end else begin
      vpn = pair_of(va, 1'b0);
      hit = ((vpn[18:0] & care[18:0]) == (e.virtual_pair_number[18:0] & care[18:0]));
    end
    entry_hit = hit && (e.all_proc || (e.tag == tag));
  endfunction

  // byte offset mask of the entry page size
  function automatic logic [31:0] offset_mask(input logic [11:0] mask);
    // run of ones widens the offset
    offset_mask = {8'h00, mask, 12'hFFF};
  endfunction

  function automatic logic [25:0] lo_pack(input page_half_s h, input logic g);
    lo_pack = {h.physical_frame, h.attr, h.write_ok, h.present, g};
  endfunction

  function automatic page_half_s lo_unpack(input logic [25:0] r);
    lo_unpack.physical_frame      = r[25:LO_PFN_LSB];
    lo_unpack.attr     = r[LO_PFN_LSB-1:LO_ATTR_LSB];
    lo_unpack.write_ok = r[LO_WRITE_BIT];
    lo_unpack.present  = r[LO_PRESENT_BIT];
  endfunction

  logic [ENTRIES-1:0] tr_match;
  logic [ENTRIES-1:0] pr_match;

  // two comparators per entry, translation and probe
  for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
    assign tr_match[g] = entry_hit(st.tlb[g], trans_req_i.vaddr, trans_req_i.mode64, st.hi_tag);
    assign pr_match[g] = entry_hit(st.tlb[g], {st.hi_region, 22'h0, st.hi_virtual_pair_number, 13'h0}, 1'b1, st.hi_tag);
  end

  always_comb begin
    logic [ENTRIES-1:0] tr_hit;
    logic [ENTRIES-1:0] pr_hit;
    logic [4:0]         tr_idx;
    logic [4:0]         pr_idx;
    logic [4:0]         wr_slot;
    tlb_entry_s         tr_e;
    tlb_entry_s         rd_e;
    tlb_entry_s         new_e;
    page_half_s         half;
    logic [31:0]        omask;
    logic [31:0]        oddbit;
    logic [31:0]        rd;
    logic [2:0]         fault;
    tr_hit  = '0;
    pr_hit  = '0;
    tr_idx  = 5'h00;
    pr_idx  = 5'h00;
    wr_slot = 5'h00;
    tr_e    = '0;
    rd_e    = '0;
    new_e   = '0;
    half    = '0;
    omask   = 32'h0000_0000;
    oddbit  = 32'h0000_0000;
    rd      = 32'h0000_0000;
    fault   = 3'b000;
    next_st = st;

    // strap input: three flops, accept once two agree
    next_st.ratio_s1 = ratio_pin_i;
    next_st.ratio_s2 = st.ratio_s1;
    next_st.ratio_s3 = st.ratio_s2;
    if (st.ratio_s2 == st.ratio_s3) begin
      next_st.clock_ratio = st.ratio_s3;
    end

    // lookup for translation and probe
    tr_hit = tr_match;
    pr_hit = pr_match;
    for (int i = 0; i < ENTRIES; i++) begin
      if (tr_hit[i]) begin
        tr_idx = 5'(i);
      end
      if (pr_hit[i]) begin
        pr_idx = 5'(i);
      end
    end

    // translation answer, one cycle after request
    tr_e   = st.tlb[tr_idx];
    omask  = offset_mask(tr_e.mask);
    oddbit = {omask[30:0], 1'b1} & ~omask;
    // present bit plays no part in the hit
    half   = ((trans_req_i.vaddr[31:0] & oddbit) != 32'h0) ? tr_e.odd : tr_e.even;
    next_st.resp          = '0;
    next_st.resp.valid    = trans_req_i.valid;
    next_st.resp.paddr    = ({half.physical_frame, 12'h000} & ~omask) | (trans_req_i.vaddr[31:0] & omask);
    next_st.resp.uncached = (half.attr == ATTR_UNCACHED);
    fault = fault_of(tr_hit != '0, half, trans_req_i.store);
    if (trans_req_i.valid) begin
      next_st.resp.refill   = fault[2];
      next_st.resp.invalid  = fault[1];
      next_st.resp.modified = fault[0];
      if (fault != 3'b000) begin
        next_st.hi_virtual_pair_number   = pair_of(trans_req_i.vaddr, trans_req_i.mode64);
        next_st.hi_region = region_of(trans_req_i.vaddr, trans_req_i.mode64);
      end
    end

    // pointer walks down, wraps at boundary
    if (instr_step_i) begin
      // boundary entry remains in random range
      if (st.random[4:0] <= st.locked[4:0]) begin
        next_st.random = RANDOM_UPPER;
      end else begin
        next_st.random = st.random - 6'h01;
      end
    end

    // buffer operations
    new_e.mask     = st.page_size;
    new_e.region   = st.hi_region;
    new_e.virtual_pair_number     = st.hi_virtual_pair_number;
    new_e.tag      = st.hi_tag;
    new_e.all_proc = st.lo0[0] & st.lo1[0];
    new_e.even     = lo_unpack(st.lo0);
    new_e.odd      = lo_unpack(st.lo1);
    // only low five index bits used
    rd_e = st.tlb[st.index[4:0]];
    case (tlb_op_i)
      OP_PROBE: begin
        next_st.probe_fail = (pr_hit == '0);
        if (pr_hit != '0) begin
          next_st.index = {1'b0, pr_idx};
        end
      end
      OP_READ: begin
        next_st.page_size = rd_e.mask;
        next_st.hi_region = rd_e.region;
        next_st.hi_virtual_pair_number   = rd_e.virtual_pair_number;
        next_st.hi_tag    = rd_e.tag;
        next_st.lo0       = lo_pack(rd_e.even, rd_e.all_proc);
        next_st.lo1       = lo_pack(rd_e.odd, rd_e.all_proc);
      end
      OP_WRITE_IDX: begin
        next_st.tlb[st.index[4:0]] = new_e;
      end
      OP_WRITE_RND: begin
        wr_slot = (st.random[4:0] < st.locked[4:0]) ? st.locked[4:0] : st.random[4:0];
        next_st.tlb[wr_slot] = new_e;
      end
      default: begin
      end
    endcase

    if (ll_valid_i) begin
      next_st.linked_load_phys = {4'h0, ll_paddr_i[31:4]};
    end
    if (tag_store_i) begin
      next_st.line_tag_low[31:28] = 4'h0;
    end

    // software register writes
    if (reg_wr_i.en) begin
      case (reg_wr_i.idx)
        REG_INDEX: begin
          next_st.index = reg_wr_i.data[5:0];
        end
        REG_LO0: begin
          next_st.lo0 = reg_wr_i.data[25:0];
        end
        REG_LO1: begin
          next_st.lo1 = reg_wr_i.data[25:0];
        end
        REG_PAGE_SIZE: begin
          next_st.page_size = reg_wr_i.data[24:MASK_LSB];
        end
        REG_LOCKED: begin
          next_st.locked = reg_wr_i.data[5:0];
          next_st.random = RANDOM_UPPER;
        end
        REG_TRANS_HIGH: begin
          next_st.hi_virtual_pair_number   = {{8{reg_wr_i.data[31]}}, reg_wr_i.data[31:HI_VPN_LSB]};
          next_st.hi_region = {2{reg_wr_i.data[31]}};
          next_st.hi_tag    = reg_wr_i.data[7:0];
        end
        REG_SETUP: begin
          next_st.writeback_pattern = reg_wr_i.data[CFG_WBPAT_LSB+3:CFG_WBPAT_LSB];
          next_st.endian_select     = reg_wr_i.data[CFG_ENDIAN_BIT];
          next_st.spare_sw_bits     = reg_wr_i.data[CFG_SPARE_BIT];
          next_st.kseg0_cache_mode  = reg_wr_i.data[2:0];
        end
        REG_LINKED: begin
          next_st.linked_load_phys = reg_wr_i.data;
        end
        REG_TAG_LOW: begin
          next_st.line_tag_low = reg_wr_i.data;
        end
        default: begin
        end
      endcase
    end

    // register read port
    case (reg_rd_idx_i)
      REG_INDEX: begin
        rd = {st.probe_fail, 25'h0, st.index};
      end
      REG_RANDOM: begin
        rd = {26'h0, st.random};
      end
      REG_LO0: begin
        rd = {6'h00, st.lo0};
      end
      REG_LO1: begin
        rd = {6'h00, st.lo1};
      end
      REG_PAGE_SIZE: begin
        rd = {7'h00, st.page_size, 13'h0000};
      end
      REG_LOCKED: begin
        rd = {26'h0, st.locked};
      end
      REG_TRANS_HIGH: begin
        rd = {st.hi_virtual_pair_number[18:0], 5'h00, st.hi_tag};
      end
      REG_IDENTITY: begin
        // kind over stepping, upper half zero
        rd = {16'h0000, PART_KIND, STEPPING};
      end
      REG_SETUP: begin
        rd = CFG_FIXED_ONES;
        rd[CFG_RATIO_LSB+2:CFG_RATIO_LSB] = st.clock_ratio;
        rd[CFG_WBPAT_LSB+3:CFG_WBPAT_LSB] = st.writeback_pattern;
        rd[CFG_ENDIAN_BIT]                = st.endian_select;
        rd[CFG_SPARE_BIT]                 = st.spare_sw_bits;
        rd[2:0]                           = st.kseg0_cache_mode;
      end
      REG_LINKED: begin
        rd = st.linked_load_phys;
      end
      REG_TAG_LOW: begin
        rd = st.line_tag_low;
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
    next_st.rd_data = rd;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.locked <= LOCKED_RESET;
      st.random <= RANDOM_UPPER;
      st.writeback_pattern <= WBPAT_EVERY;
      st.endian_select     <= ENDIAN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rd_data_o = st.rd_data;
  assign trans_resp_o  = st.resp;
  assign endian_select_o     = st.endian_select;
  assign writeback_pattern_o = st.writeback_pattern;
  assign kseg0_cache_mode_o  = st.kseg0_cache_mode;

endmodule

// File: design/tlb_ctrl_pkg.sv
// constants, types and register map of the translation control block
// Functional notes
// - page size mask is right-aligned run of ones
// - write-random never replaces locked entries
// - boundary six bits, only 4:0 used
// - entry at boundary index stays replaceable
// - cold reset clears locked boundary
// - boundary write forces pointer to 31
// - pointer decrements per instruction, boundary..31
// - exceptions load translation_high pair and region, tag kept
// - identity: stepping 7:0, part kind 15:8
// - cold reset: writeback_pattern 0000, endian 1
// - spare bits and kseg0 mode software-only
// - clock_ratio read-only ratio code
// - writeback_pattern selects system port data pattern
// - endian_select 0 little, 1 big
// - attribute 010 bypasses the cache
// - load-linked stores address, top nibble zero
// - line_tag_low holds tag and state
// - index-store-tag zeroes tag upper nibble
// - process tag compared unless all-process bit
// - compare 7..19 or 15..27 top bits
// - match yields frame and attribute bits
// - miss, invalid and modification exceptions
package tlb_ctrl_pkg;

  localparam int unsigned ENTRIES = 32;

  // coprocessor register numbers
  localparam logic [4:0] REG_INDEX      = 5'h00;
  localparam logic [4:0] REG_RANDOM     = 5'h01;
  localparam logic [4:0] REG_LO0        = 5'h02;
  localparam logic [4:0] REG_LO1        = 5'h03;
  localparam logic [4:0] REG_PAGE_SIZE  = 5'h05;
  localparam logic [4:0] REG_LOCKED     = 5'h06;
  localparam logic [4:0] REG_TRANS_HIGH = 5'h0A;
  localparam logic [4:0] REG_IDENTITY   = 5'h0F;
  localparam logic [4:0] REG_SETUP      = 5'h10;
  localparam logic [4:0] REG_LINKED     = 5'h11;
  localparam logic [4:0] REG_TAG_LOW    = 5'h1C;
  localparam logic [4:0] REG_TAG_HIGH   = 5'h1D;

  // page size masks
  localparam logic [11:0] MASK_4K   = 12'h000;
  localparam logic [11:0] MASK_16K  = 12'h003;
  localparam logic [11:0] MASK_64K  = 12'h00F;
  localparam logic [11:0] MASK_256K = 12'h03F;
  localparam logic [11:0] MASK_1M   = 12'h0FF;
  localparam logic [11:0] MASK_4M   = 12'h3FF;
  localparam logic [11:0] MASK_16M  = 12'hFFF;
  localparam int unsigned MASK_LSB  = 13;

  // field positions
  localparam int unsigned IDX_PROBE_FAIL = 31;
  localparam int unsigned LO_PFN_LSB     = 6;
  localparam int unsigned LO_ATTR_LSB    = 3;
  localparam int unsigned LO_WRITE_BIT   = 2;
  localparam int unsigned LO_PRESENT_BIT = 1;
  localparam int unsigned HI_VPN_LSB     = 13;
  localparam int unsigned CFG_RATIO_LSB  = 28;
  localparam int unsigned CFG_WBPAT_LSB  = 24;
  localparam int unsigned CFG_ENDIAN_BIT = 15;
  localparam int unsigned CFG_SPARE_BIT  = 3;
  localparam int unsigned TAG_PTAG_LSB   = 8;
  localparam int unsigned TAG_STATE_LSB  = 6;

  // constant bits of the setup register
  localparam logic [31:0] CFG_FIXED_ONES = 32'h0006_6460;

  // reset values and encodings
  localparam logic [5:0]  LOCKED_RESET   = 6'h00;
  localparam logic [5:0]  RANDOM_UPPER   = 6'h1F;
  localparam logic [3:0]  WBPAT_EVERY    = 4'h0;
  localparam logic [3:0]  WBPAT_TWO_SIX  = 4'h6;
  localparam logic        ENDIAN_RESET   = 1'b1;
  localparam logic [2:0]  ATTR_UNCACHED  = 3'h2;
  localparam logic [1:0]  STATE_DIRTY    = 2'h3;
  localparam logic [1:0]  STATE_INVALID  = 2'h0;
  localparam logic [2:0]  RATIO_1_1      = 3'h6;
  localparam logic [2:0]  RATIO_15_1     = 3'h7;
  localparam logic [2:0]  RATIO_2_1      = 3'h0;
  localparam logic [2:0]  RATIO_3_1      = 3'h1;

  typedef enum logic [2:0] {
    OP_NONE      = 3'b000,
    OP_PROBE     = 3'b001,
    OP_READ      = 3'b010,
    OP_WRITE_IDX = 3'b011,
    OP_WRITE_RND = 3'b100
  } tlb_op_e;

  typedef struct packed {
    logic [19:0] physical_frame;
    logic [2:0]  attr;
    logic        write_ok;
    logic        present;
  } page_half_s;

  typedef struct packed {
    logic [11:0] mask;
    logic [1:0]  region;
    logic [26:0] virtual_pair_number;
    logic        all_proc;
    logic [7:0]  tag;
    page_half_s  even;
    page_half_s  odd;
  } tlb_entry_s;

  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [31:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic        valid;
    logic [63:0] vaddr;
    logic        mode64;
    logic        store;
  } trans_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] paddr;
    logic        uncached;
    logic        refill;
    logic        invalid;
    logic        modified;
  } trans_resp_s;

endpackage

// File: testbench/tlb_translation_control_regs_assertions.sv
// port assertions of the translation control block
`timescale 1ns/1ps
module tlb_ctrl_checker #(
  parameter logic [7:0] PART_KIND = 8'h5A,
  parameter logic [7:0] STEPPING  = 8'h10
) (
  input wire logic                      clock_i,
  input wire logic                      rst_i,
  input wire tlb_ctrl_pkg::reg_wr_s     reg_wr_i,
  input wire logic [4:0]                reg_rd_idx_i,
  input wire logic [31:0]               reg_rd_data_o,
  input wire tlb_ctrl_pkg::trans_req_s  trans_req_i,
  input wire tlb_ctrl_pkg::trans_resp_s trans_resp_o,
  input wire logic                      ll_valid_i,
  input wire logic [31:0]               ll_paddr_i,
  input wire logic                      tag_store_i,
  input wire logic [3:0]                writeback_pattern_o,
  input wire logic                      endian_select_o,
  input wire logic [2:0]                kseg0_cache_mode_o
);
  import tlb_ctrl_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic ws;
  logic wl;
  assign ws = reg_wr_i.en && reg_wr_i.idx == REG_SETUP;
  assign wl = reg_wr_i.en && reg_wr_i.idx == REG_LOCKED;
  property p_ll;
    logic [31:0] pa;
    (ll_valid_i && !reg_wr_i.en, pa = ll_paddr_i) ##1 (reg_rd_idx_i == REG_LINKED && !ll_valid_i && !reg_wr_i.en)
      |=> reg_rd_data_o == {4'h0, pa[31:4]};
  endproperty
  a_resp_after_req: assert property (trans_req_i.valid |=> trans_resp_o.valid)
    else $error("translation answer missing");
  a_no_stray_resp: assert property (!trans_req_i.valid |=> !trans_resp_o.valid)
    else $error("translation answer without request");
  a_one_exception: assert property (trans_resp_o.valid |-> $onehot0({trans_resp_o.refill, trans_resp_o.invalid, trans_resp_o.modified}))
    else $error("more than one exception flag");
  a_modify_on_store: assert property (trans_resp_o.modified |-> $past(trans_req_i.store))
    else $error("modification flag on a load");
  a_pattern_write: assert property (ws |=> writeback_pattern_o == $past(reg_wr_i.data[27:24]))
    else $error("pattern output not updated");
  a_endian_write: assert property (ws |=> endian_select_o == $past(reg_wr_i.data[15]))
    else $error("endian output not updated");
  a_kseg0_write: assert property (ws |=> kseg0_cache_mode_o == $past(reg_wr_i.data[2:0]))
    else $error("kseg0 mode not updated");
  a_random_top: assert property (wl ##1 (reg_rd_idx_i == REG_RANDOM) |=> reg_rd_data_o == 32'h1F)
    else $error("pointer not at upper bound");
  a_ll_zero_top: assert property (p_ll)
    else $error("linked address top nibble wrong");
  a_tag_top_zero: assert property (tag_store_i && !reg_wr_i.en ##1 (reg_rd_idx_i == REG_TAG_LOW && !reg_wr_i.en)
    |=> reg_rd_data_o[31:28] == 4'h0)
    else $error("tag top nibble not cleared");
  a_identity_fixed: assert property (reg_rd_idx_i == REG_IDENTITY |=> reg_rd_data_o == {16'h0, PART_KIND, STEPPING})
    else $error("identity value wrong");
  c_refill: cover property (trans_resp_o.valid && trans_resp_o.refill);
  c_invalid: cover property (trans_resp_o.valid && trans_resp_o.invalid);
  c_uncached: cover property (trans_resp_o.valid && trans_resp_o.uncached);
endmodule

// File: testbench/pipe_model.sv
// processor side model issuing translations and instruction steps
`timescale 1ns/1ps
module pipe_model (
  input  wire logic                      clock_i,
  input  wire tlb_ctrl_pkg::trans_resp_s resp_i,
  output tlb_ctrl_pkg::trans_req_s       req_o,
  output logic                           step_o
);
  import tlb_ctrl_pkg::*;
  initial begin
    req_o = '0;
    step_o = 1'b0;
  end
  task automatic translate(input logic [63:0] va, input logic m64, input logic st, output trans_resp_s r);
    @(posedge clock_i);
    #1 req_o = {1'b1, va, m64, st};
    @(posedge clock_i);
    #1 req_o.valid = 1'b0;
    r = resp_i;
  endtask
  task automatic step(input int n);
    @(posedge clock_i);
    #1 step_o = 1'b1;
    repeat (n) @(posedge clock_i);
    #1 step_o = 1'b0;
  endtask
endmodule

// File: testbench/tb.sv
// self-checking bench of the translation control block
`timescale 1ns/1ps
module tb;
  import tlb_ctrl_pkg::*;
  localparam logic [7:0] ID_KIND = 8'h3C; // arbitrary value
  localparam logic [7:0] ID_STEP = 8'h21; // arbitrary value
  logic        clock_i;
  logic        rst_i;
  reg_wr_s     reg_wr;
  logic [4:0]  rd_idx;
  logic [31:0] rd_data;
  tlb_op_e     tlb_op;
  logic        step;
  trans_req_s  req;
  trans_resp_s resp;
  logic        ll_valid;
  logic [31:0] ll_paddr;
  logic        tag_store;
  logic [2:0]  ratio;
  logic [3:0]  pat;
  logic        endian;
  logic [2:0]  k0;
  logic        wide_mode;
  int          comparisons;
  int          miscompares;
  logic [2:0]  ratios [4] = '{RATIO_1_1, RATIO_15_1, RATIO_2_1, RATIO_3_1};
  tlb_translation_control_regs #(.PART_KIND(ID_KIND), .STEPPING(ID_STEP)) u_tlb_translation_control_regs (
    .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_idx_i(rd_idx), .reg_rd_data_o(rd_data),
    .tlb_op_i(tlb_op), .instr_step_i(step), .trans_req_i(req), .trans_resp_o(resp), .ll_valid_i(ll_valid),
    .ll_paddr_i(ll_paddr), .tag_store_i(tag_store), .ratio_pin_i(ratio), .writeback_pattern_o(pat),
    .endian_select_o(endian), .kseg0_cache_mode_o(k0));
  pipe_model u_pipe_model (.clock_i(clock_i), .resp_i(resp), .req_o(req), .step_o(step));
  task automatic print_verdict;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    #1 reg_wr = {1'b1, a, d};
    @(posedge clock_i);
    #1 reg_wr.en = 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    #1 rd_idx = a;
    @(posedge clock_i);
    #1 chk(rd_data, exp);
  endtask
  task automatic op(input tlb_op_e o);
    @(posedge clock_i);
    #1 tlb_op = o;
    @(posedge clock_i);
    #1 tlb_op = OP_NONE;
  endtask
  task automatic ent(input logic [31:0] hi, input logic [31:0] mask, input logic [31:0] lo0, input logic [31:0] lo1);
    wr(REG_TRANS_HIGH, hi);
    wr(REG_PAGE_SIZE, mask);
    wr(REG_LO0, lo0);
    wr(REG_LO1, lo1);
  endtask
  task automatic tr(input logic [63:0] va, input logic st, input logic [31:0] pa, input logic [3:0] f);
    trans_resp_s r;
    u_pipe_model.translate(va, wide_mode, st, r);
    chk({29'h0, r.refill, r.invalid, r.modified}, {29'h0, f[2:0]});
    if (f[2:0] == 3'h0) begin
      chk(r.paddr, pa);
      chk({31'h0, r.uncached}, {31'h0, f[3]});
    end
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
  initial begin
    rst_i = 1'b1;
    reg_wr = '0;
    rd_idx = 5'h00;
    tlb_op = OP_NONE;
    ll_valid = 1'b0;
    ll_paddr = 32'h0;
    tag_store = 1'b0;
    ratio = RATIO_2_1;
    wide_mode = 1'b0;
    comparisons = 0;
    miscompares = 0;
    repeat (10) @(posedge clock_i);
    #1 rst_i = 1'b0;
    chk({24'h0, pat, endian, k0}, {24'h0, WBPAT_EVERY, ENDIAN_RESET, 3'h0});
    rc(REG_LOCKED, 32'h0);
    rc(REG_RANDOM, 32'h1F);
    rc(REG_IDENTITY, {16'h0, ID_KIND, ID_STEP});
    rc(REG_TAG_HIGH, 32'h0);
    rc(5'h07, 32'h0);
    foreach (ratios[i]) begin
      ratio = ratios[i];
      repeat (5) @(posedge clock_i);
      rc(REG_SETUP, CFG_FIXED_ONES | {1'b0, ratios[i], WBPAT_EVERY, 8'h0, ENDIAN_RESET, 15'h0});
    end
    wr(REG_SETUP, CFG_FIXED_ONES | {4'h0, WBPAT_TWO_SIX, 20'h0, 4'hA});
    rc(REG_SETUP, CFG_FIXED_ONES | {1'b0, RATIO_3_1, WBPAT_TWO_SIX, 20'h0, 4'hA});
    chk({24'h0, pat, endian, k0}, {24'h0, WBPAT_TWO_SIX, 1'b0, 3'h2});
    wr(REG_SETUP, CFG_FIXED_ONES | 32'h0000_8000);
    chk({24'h0, pat, endian, k0}, {24'h0, WBPAT_EVERY, 1'b1, 3'h0});
    rd_idx = REG_RANDOM;
    wr(REG_LOCKED, 32'h25);
    rc(REG_RANDOM, 32'h1F);
    rc(REG_LOCKED, 32'h25);
    u_pipe_model.step(26);
    rc(REG_RANDOM, 32'h05);
    u_pipe_model.step(1);
    rc(REG_RANDOM, 32'h1F);
    wr(REG_INDEX, 32'h3);
    ent(32'h0040_2011, 32'h0, {6'h0, 20'h00123, ATTR_UNCACHED, 3'b110}, {6'h0, 20'h00456, 3'h3, 3'b010});
    op(OP_WRITE_IDX);
    tr(64'h0040_2010, 1'b0, 32'h0012_3010, 4'b1000);
    tr(64'h0040_3004, 1'b0, 32'h0045_6004, 4'b0000);
    tr(64'h0040_3004, 1'b1, 32'h0, 4'b0001);
    ent(32'h00C0_0011, 32'h0, {6'h0, 20'h00777, 3'h3, 3'b110}, {6'h0, 20'h00778, 3'h3, 3'b110});
    op(OP_WRITE_RND);
    wr(REG_INDEX, 32'h1F);
    op(OP_READ);
    rc(REG_TRANS_HIGH, 32'h00C0_0011);
    tr(64'h0040_2010, 1'b0, 32'h0012_3010, 4'b1000);
    tr(64'h00C0_0008, 1'b0, 32'h0077_7008, 4'b0000);
    wr(REG_TRANS_HIGH, 32'h0040_2011);
    op(OP_PROBE);
    rc(REG_INDEX, 32'h3);
    wr(REG_TRANS_HIGH, 32'h0040_2022);
    op(OP_PROBE);
    rc(REG_INDEX, 32'h8000_0003);
    tr(64'h0040_2010, 1'b0, 32'h0, 4'b0100);
    tr(64'h0080_4010, 1'b0, 32'h0, 4'b0100);
    rc(REG_TRANS_HIGH, 32'h0080_4022);
    wr(REG_INDEX, 32'h6);
    ent(32'h0100_0033, {7'h0, MASK_16K, 13'h0}, {6'h0, 20'h00100, 3'h3, 3'b101}, {6'h0, 20'h00084, 3'h3, 3'b111});
    op(OP_WRITE_IDX);
    tr(64'h0100_6010, 1'b0, 32'h0008_6010, 4'b0000);
    tr(64'h0100_2010, 1'b0, 32'h0, 4'b0010);
    wide_mode = 1'b1;
    tr(64'h0000_0000_0100_6010, 1'b0, 32'h0008_6010, 4'b0000);
    tr(64'h0000_0010_0100_6010, 1'b0, 32'h0, 4'b0100);
    wide_mode = 1'b0;
    op(OP_READ);
    rc(REG_PAGE_SIZE, 32'h0000_6000);
    #0 {ll_valid, ll_paddr, rd_idx} = {1'b1, 32'hFFFF_1234, REG_LINKED};
    @(posedge clock_i);
    #1 ll_valid = 1'b0;
    rc(REG_LINKED, 32'h0FFF_F123);
    wr(REG_LINKED, 32'hFFFF_FFFF);
    rc(REG_LINKED, 32'hFFFF_FFFF);
    wr(REG_TAG_LOW, 32'hF123_45C0);
    rc(REG_TAG_LOW, 32'hF123_45C0);
    {tag_store, rd_idx} = {1'b1, REG_TAG_LOW};
    @(posedge clock_i);
    #1 tag_store = 1'b0;
    rc(REG_TAG_LOW, 32'h0123_45C0);
    print_verdict();
  end
endmodule
bind tlb_translation_control_regs tlb_ctrl_checker #(.PART_KIND(PART_KIND), .STEPPING(STEPPING)) u_tlb_ctrl_checker (
  .clock_i, .rst_i, .reg_wr_i, .reg_rd_idx_i, .reg_rd_data_o, .trans_req_i, .trans_resp_o, .ll_valid_i,
  .ll_paddr_i, .tag_store_i, .writeback_pattern_o, .endian_select_o, .kseg0_cache_mode_o);
